// >>> txpo_pkg.sv
// Constants and types for the transmit path-overhead generator.
`default_nettype none
package txpo_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [13:0] IX_CTRL = 14'h19b7;
    localparam logic [13:0] IX_ARB_HI = 14'h19bf;
    localparam logic [13:0] IX_ARB_LO = 14'h19c3;
    localparam logic [13:0] IX_CFG = 14'h19d0;
    localparam logic [13:0] IX_MASK = 14'h19d1;
    localparam logic [13:0] IX_C2 = 14'h19d2;
    localparam logic [13:0] IX_F2 = 14'h19d3;
    localparam logic [13:0] IX_Z3 = 14'h19d4;
    localparam logic [13:0] IX_Z4 = 14'h19d5;
    localparam logic [13:0] IX_Z5 = 14'h19d6;
    localparam logic [13:0] IX_TADDR = 14'h19d7;
    localparam logic [13:0] IX_TDATA = 14'h19d8;
    localparam logic [13:0] IX_PTR_LO = 14'h19d9;
    localparam logic [13:0] IX_STAT = 14'h19da;
    localparam logic [13:0] IX_B3 = 14'h19db;
    localparam logic [7:0] REG_RST = 8'h00;
    // Path control bits.
    localparam int CB_SNDF = 0;
    localparam int CB_CNDF = 1;
    localparam int CB_PSTF = 2;
    localparam int CB_NSTF = 3;
    localparam int CB_CHK = 4;
    localparam int CB_FRC = 5;
    // Configuration bits; trace length occupies two bits from FB_TLEN.
    localparam int FB_AIS = 0;
    localparam int FB_RDI = 1;
    localparam int FB_REI = 2;
    localparam int FB_PPP = 3;
    localparam int FB_TLEN = 4;
    // Frame geometry.
    localparam logic [3:0] ROWS = 4'h9;
    localparam logic [8:0] TOH_COLS = 9'h009;
    localparam logic [8:0] SPE_COLS = 9'h105;
    localparam logic [8:0] COLS = TOH_COLS + SPE_COLS;
    localparam logic [3:0] H_ROW = 4'h3;
    localparam logic [8:0] H1_COL = 9'h000;
    localparam logic [8:0] H2_COL = 9'h003;
    localparam logic [8:0] H3_COL = 9'h006;
    localparam logic [8:0] PSTF_COL = 9'h00a;
    localparam logic [3:0] ROW_J1 = 4'h0;
    localparam logic [3:0] ROW_B3 = 4'h1;
    localparam logic [3:0] ROW_C2 = 4'h2;
    localparam logic [3:0] ROW_G1 = 4'h3;
    localparam logic [3:0] ROW_F2 = 4'h4;
    localparam logic [3:0] ROW_H4 = 4'h5;
    localparam logic [3:0] ROW_Z3 = 4'h6;
    localparam logic [3:0] ROW_Z4 = 4'h7;
    localparam logic [3:0] ROW_Z5 = 4'h8;
    // Pointer word.
    localparam logic [3:0] NDF_ON = 4'h9;
    localparam logic [3:0] NDF_OFF = 4'h6;
    localparam logic [1:0] SS_BITS = 2'h0;
    localparam logic [9:0] I_MASK = 10'h2aa;
    localparam logic [9:0] D_MASK = 10'h155;
    localparam logic [9:0] PTR_MAX = 10'h30e;
    localparam logic [9:0] PTR_RST = 10'h20a;
    // Fill bytes and counts.
    localparam logic [7:0] AIS_BYTE = 8'hff;
    localparam logic [7:0] TOH_FILL = 8'h00;
    localparam logic [7:0] STUFF_BYTE = 8'h00;
    localparam logic [7:0] H4_BYTE = 8'h00;
    localparam logic [7:0] IDLE_ATM = 8'h00;
    localparam logic [7:0] IDLE_PPP = 8'h7e;
    localparam logic [3:0] REI_MAX = 4'h8;
    localparam logic [3:0] REI_ONE = 4'h1;
    localparam int TRACE_DEPTH = 64;
    localparam logic [5:0] TRACE_LAST_1 = 6'h00;
    localparam logic [5:0] TRACE_LAST_16 = 6'h0f;
    localparam logic [5:0] TRACE_LAST_64 = 6'h3f;

    typedef enum logic [1:0] {
        EV_NORM = 2'h0,
        EV_NDF = 2'h1,
        EV_INC = 2'h3,
        EV_DEC = 2'h2
    } txpo_ev_t;

    typedef enum logic [2:0] {
        SL_TOH, SL_H1, SL_H2, SL_H3, SL_POH, SL_PAY, SL_STUFF
    } txpo_slot_t;

    typedef struct packed {
        logic valid;
        logic sof;
        logic [3:0] row;
        logic [8:0] col;
        logic [7:0] data;
    } txpo_byte_t;

    typedef struct packed {
        logic ais;
        logic lop;
        logic uneq;
        logic tim;
        logic plm;
        logic lcd;
    } txpo_defect_t;

    typedef struct packed {
        logic valid;
        logic [3:0] count;
    } txpo_rei_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } txpo_pay_t;
endpackage : txpo_pkg
`default_nettype wire

// >>> txpo_top.sv
// Transmit path-overhead and pointer generator with its APB registers.
//
// Functional notes
// R01: Single flag trigger makes next frame carry flag nibble 1001.
// R02: That frame carries the ten pointer bits from the arbitrary registers.
// R03: Later frames return nibble to 0110 and keep the new pointer.
// R04: The single flag trigger bit clears itself after a written one.
// R05: Software loads the arbitrary pointer registers before triggering.
// R06: Arbitrary high register: flag nibble, size bits, pointer top bits.
// R07: Cells from the upstream cell processor fill payload bytes.
// R08: Alternatively packets from the packet processor fill payload bytes.
// R09: Even interleaved parity of each envelope goes into next B3.
// R10: Envelope is 9 rows by 261 columns; first column is overhead.
// R11: Path overhead bytes come from configuration registers.
// R12: The multiframe byte carries no meaning here.
// R13: Remote defect sent while receive path declares a path defect.
// R14: Remote defect sent while cell delineation is lost.
// R15: Remote defect sent on software command.
// R16: Remote error count follows receive-side parity errors.
// R17: Remote error sent on software command.
// R18: Path alarm sent only on software command.
// R19: Trace message of 1, 16 or 64 bytes repeats in J1.
// R20: B3 can be sent wrong on purpose for testing.
// R21: Software forces stuffs and single or continuous flag events.
// R22: Finished byte stream goes to the transport-overhead stage.
// R23: B3 is XORed with the error mask; zero mask leaves it intact.
// R24: Positive stuff: stuff byte after H3, invert I bits, pointer plus one.
// R25: Negative stuff: payload in H3, invert D bits, pointer minus one.
// R26: Each written trigger one gives exactly one event at frame boundary; the force bit gives one only when it was zero before the write.
`default_nettype none
module txpo_top
    import txpo_pkg::*;
(
    // Clock, reset and freeze.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave.
    input wire logic [15:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Upstream cell and packet bytes.
    input wire txpo_pay_t cell_in,
    output logic cell_ready,
    input wire txpo_pay_t pkt_in,
    output logic pkt_ready,
    // Receive-side defects and far-end error counts.
    input wire txpo_defect_t rx_def,
    input wire txpo_rei_t rx_rei,
    // Byte stream toward the transport-overhead stage.
    output txpo_byte_t tx_out
);
    logic [7:0] arb_hi_q, arb_lo_q, cfg_q, mask_q;
    logic [7:0] c2_q, f2_q, z3_q, z4_q, z5_q;
    logic cndf_q, chk_q, frc_q;
    logic pend_sndf_q, pend_pstf_q, pend_nstf_q, pend_frc_q;
    logic [5:0] taddr_q;
    logic [7:0] trace_mem [TRACE_DEPTH];
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic [3:0] row_q, row_d;
    logic [8:0] col_q, col_d;
    txpo_ev_t ev_q, ev_d;
    logic [7:0] ndf_h1_q, ndf_lo_q;
    logic [9:0] ptr_q, ptr_d;
    logic [7:0] b3_q, b3_acc_q;
    logic [3:0] rei_q;
    logic [5:0] tidx_q;
    logic cell_ready_q, pkt_ready_q;
    logic ndf_plain_q;
    txpo_byte_t out_q;
    logic [7:0] rd_val, poh_val, byte_d;
    logic rd_hit;

    // Slot kind of a frame position; the event decides H3 and stuff use.
    function automatic txpo_slot_t slot_of(input logic [3:0] r,
                                           input logic [8:0] c,
                                           input txpo_ev_t ev);
        if (c < TOH_COLS) begin
            if (r == H_ROW && c == H1_COL) begin
                return SL_H1;
            end else if (r == H_ROW && c == H2_COL) begin
                return SL_H2;
            end else if (r == H_ROW && c == H3_COL) begin
                return (ev == EV_DEC) ? SL_PAY : SL_H3; // R25
            end
            return SL_TOH;
        end else if (c == TOH_COLS) begin
            return SL_POH; // R10
        end else if (r == H_ROW && c == PSTF_COL && ev == EV_INC) begin
            return SL_STUFF; // R24
        end
        return SL_PAY;
    endfunction : slot_of

    // APB decode.
    wire logic [13:0] ix = paddr[15:2];
    wire logic setup = psel && !penable;
    wire logic wr = psel && penable && pready_q && pwrite && pstrb[0];
    wire logic [7:0] wd = pwdata[7:0];

    function automatic logic wr_to(input logic [13:0] idx);
        return wr && ix == idx;
    endfunction : wr_to

    // Written out here: a continuous assignment does not see the signals
    // that a function reads from the module, only its arguments.
    wire logic wr_ctrl = wr && ix == IX_CTRL;
    wire logic set_sndf = wr_ctrl && wd[CB_SNDF];
    wire logic set_cndf = wr_ctrl && wd[CB_CNDF];
    wire logic set_pstf = wr_ctrl && wd[CB_PSTF];
    wire logic set_nstf = wr_ctrl && wd[CB_NSTF];
    wire logic set_frc = wr_ctrl && wd[CB_FRC] && !frc_q;

    // Framing position.
    wire logic col_last = col_q == COLS - 9'h001;
    wire logic row_last = row_q == ROWS - 4'h1;
    wire logic fr_end = ce && col_last && row_last;
    assign col_d = col_last ? 9'h000 : col_q + 9'h001; // R10
    assign row_d = !col_last ? row_q : row_last ? 4'h0 : row_q + 4'h1;

    // Frame event choice: force, then flag events, then stuffs.
    wire logic take_frc = fr_end && pend_frc_q;
    wire logic ndf_go = fr_end && !pend_frc_q && (pend_sndf_q || cndf_q);
    wire logic take_sndf = ndf_go && pend_sndf_q; // R26
    wire logic adj_ok = fr_end && !pend_frc_q && !pend_sndf_q && !cndf_q;
    wire logic take_pstf = adj_ok && pend_pstf_q; // R21
    wire logic take_nstf = adj_ok && !pend_pstf_q && pend_nstf_q; // R21
    assign ev_d = !fr_end ? ev_q :
                  (take_frc || ndf_go) ? EV_NDF :
                  take_pstf ? EV_INC :
                  take_nstf ? EV_DEC : EV_NORM;

    wire txpo_slot_t slot = slot_of(row_q, col_q, ev_q);
    wire txpo_slot_t slot_nx = slot_of(row_d, col_d, ev_d);

    // Configuration view.
    wire logic ais = cfg_q[FB_AIS];
    wire logic ppp = cfg_q[FB_PPP];
    wire logic [1:0] tlen = cfg_q[FB_TLEN +: 2];
    wire logic [5:0] tlast = (tlen == 2'h0) ? TRACE_LAST_1 :
                             (tlen == 2'h1) ? TRACE_LAST_16 : TRACE_LAST_64;
    wire logic rdi_tx = (|rx_def) || cfg_q[FB_RDI]; // R13 R14 R15
    wire logic [3:0] rei_tx = (cfg_q[FB_REI] && rei_q == 4'h0) ? REI_ONE :
                              rei_q; // R17
    wire logic [7:0] g1_val = {rei_tx, rdi_tx, 3'h0};

    // Pointer bytes; the adjustment frame inverts I or D bits.
    wire logic [9:0] ptr_word = ptr_q ^ ((ev_q == EV_INC) ? I_MASK :
                                (ev_q == EV_DEC) ? D_MASK : 10'h000);
    wire logic ndf_frame = ev_q == EV_NDF;
    wire logic [7:0] h1_val = ndf_frame ? ndf_h1_q :
                              {NDF_OFF, SS_BITS, ptr_word[9:8]}; // R03
    wire logic [7:0] h2_val = ndf_frame ? ndf_lo_q : ptr_word[7:0]; // R02

    // Payload source.
    wire txpo_pay_t src = ppp ? pkt_in : cell_in; // R08
    wire logic src_rdy = ppp ? pkt_ready_q : cell_ready_q;
    wire logic take_in = ce && src_rdy && src.valid; // R07
    wire logic [7:0] idle = ppp ? IDLE_PPP : IDLE_ATM;
    wire logic [7:0] pay_byte = take_in ? src.data : idle;
    wire logic pay_nx = slot_nx == SL_PAY && !ais;

    wire logic [7:0] ctrl_rd = {2'h0, frc_q, chk_q, pend_nstf_q, pend_pstf_q,
                                cndf_q, pend_sndf_q};
    wire logic [7:0] stat_rd = {ev_q, rdi_tx, 3'h0, ptr_q[9:8]};

    always_comb begin
        rd_hit = 1'b1;
        case (ix)
            IX_CTRL: rd_val = ctrl_rd;
            IX_ARB_HI: rd_val = arb_hi_q;
            IX_ARB_LO: rd_val = arb_lo_q;
            IX_CFG: rd_val = cfg_q;
            IX_MASK: rd_val = mask_q;
            IX_C2: rd_val = c2_q;
            IX_F2: rd_val = f2_q;
            IX_Z3: rd_val = z3_q;
            IX_Z4: rd_val = z4_q;
            IX_Z5: rd_val = z5_q;
            IX_TADDR: rd_val = {2'h0, taddr_q};
            IX_TDATA: rd_val = trace_mem[taddr_q];
            IX_PTR_LO: rd_val = ptr_q[7:0];
            IX_STAT: rd_val = stat_rd;
            IX_B3: rd_val = b3_q;
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Path overhead column.
    always_comb begin
        case (row_q)
            ROW_J1: poh_val = trace_mem[tidx_q]; // R19
            ROW_B3: poh_val = b3_q ^ mask_q; // R09 R20 R23
            ROW_C2: poh_val = c2_q; // R11
            ROW_G1: poh_val = g1_val;
            ROW_F2: poh_val = f2_q;
            ROW_H4: poh_val = H4_BYTE; // R12
            ROW_Z3: poh_val = z3_q;
            ROW_Z4: poh_val = z4_q;
            ROW_Z5: poh_val = z5_q;
            default: poh_val = TOH_FILL;
        endcase
    end

    // Outgoing byte; path alarm overrides all but plain overhead.
    always_comb begin
        unique case (slot)
            SL_TOH: byte_d = TOH_FILL;
            SL_H1: byte_d = h1_val;
            SL_H2: byte_d = h2_val;
            SL_H3: byte_d = TOH_FILL;
            SL_POH: byte_d = poh_val;
            SL_STUFF: byte_d = STUFF_BYTE;
            SL_PAY: byte_d = pay_byte;
            default: byte_d = TOH_FILL;
        endcase
        if (ais && slot != SL_TOH) begin
            byte_d = AIS_BYTE; // R18
        end
    end

    wire logic in_spe = slot == SL_POH || slot == SL_PAY || slot == SL_STUFF;
    wire logic [7:0] b3_sum = b3_acc_q ^ (in_spe ? byte_d : 8'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= setup;
            if (setup) begin
                prdata_q <= {24'h0, rd_val};
                pslverr_q <= !rd_hit;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arb_hi_q <= REG_RST;
            arb_lo_q <= REG_RST;
            cfg_q <= REG_RST;
            mask_q <= REG_RST;
            c2_q <= REG_RST;
            f2_q <= REG_RST;
            z3_q <= REG_RST;
            z4_q <= REG_RST;
            z5_q <= REG_RST;
            cndf_q <= 1'b0;
            chk_q <= 1'b0;
            frc_q <= 1'b0;
            taddr_q <= 6'h00;
        end else begin
            if (wr_ctrl) begin
                cndf_q <= set_cndf;
                chk_q <= wd[CB_CHK];
                frc_q <= wd[CB_FRC];
            end
            if (wr_to(IX_ARB_HI)) arb_hi_q <= wd; // R06
            if (wr_to(IX_ARB_LO)) arb_lo_q <= wd;
            if (wr_to(IX_CFG)) cfg_q <= wd;
            if (wr_to(IX_MASK)) mask_q <= wd;
            if (wr_to(IX_C2)) c2_q <= wd;
            if (wr_to(IX_F2)) f2_q <= wd;
            if (wr_to(IX_Z3)) z3_q <= wd;
            if (wr_to(IX_Z4)) z4_q <= wd;
            if (wr_to(IX_Z5)) z5_q <= wd;
            if (wr_to(IX_TADDR)) begin
                taddr_q <= wd[5:0];
            end else if (wr_to(IX_TDATA)) begin
                taddr_q <= taddr_q + 6'h01;
            end
        end
    end

    // Cleared at reset so an unwritten trace byte never spoils B3.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < TRACE_DEPTH; i++) trace_mem[i] <= 8'h00;
        end else if (wr_to(IX_TDATA)) begin
            trace_mem[taddr_q] <= wd;
        end
    end

    // Triggers clear themselves when taken; a new write wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_sndf_q <= 1'b0;
            pend_pstf_q <= 1'b0;
            pend_nstf_q <= 1'b0;
            pend_frc_q <= 1'b0;
        end else begin
            pend_sndf_q <= (pend_sndf_q && !take_sndf) || set_sndf; // R04
            pend_pstf_q <= (pend_pstf_q && !take_pstf) || set_pstf; // R24
            pend_nstf_q <= (pend_nstf_q && !take_nstf) || set_nstf; // R25
            pend_frc_q <= (pend_frc_q && !take_frc) || set_frc; // R26
        end
    end

    always_comb begin
        unique case (ev_q)
            EV_NORM: ptr_d = ptr_q;
            EV_NDF: ptr_d = {ndf_h1_q[1:0], ndf_lo_q}; // R03
            EV_INC: ptr_d = (ptr_q == PTR_MAX) ? 10'h000 : ptr_q + 10'h001;
            EV_DEC: ptr_d = (ptr_q == 10'h000) ? PTR_MAX : ptr_q - 10'h001;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_q <= 4'h0;
            col_q <= 9'h000;
            ev_q <= EV_NORM;
            ndf_h1_q <= 8'h00;
            ndf_lo_q <= 8'h00;
            ndf_plain_q <= 1'b0;
            ptr_q <= PTR_RST;
            tidx_q <= 6'h00;
        end else if (ce) begin
            row_q <= row_d;
            col_q <= col_d;
            ev_q <= ev_d;
            if (take_frc) begin
                ndf_h1_q <= arb_hi_q; // R06
            end else if (ndf_go) begin
                ndf_h1_q <= {NDF_ON, SS_BITS, arb_hi_q[1:0]}; // R01 R02
            end
            if (take_frc || ndf_go) ndf_lo_q <= arb_lo_q; // R02
            if (fr_end) begin
                ndf_plain_q <= ndf_go;
                ptr_q <= ptr_d; // R24 R25
                tidx_q <= (tidx_q >= tlast) ? 6'h00 : tidx_q + 6'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b3_acc_q <= 8'h00;
            b3_q <= 8'h00;
            rei_q <= 4'h0;
            cell_ready_q <= 1'b0;
            pkt_ready_q <= 1'b0;
            out_q <= '0;
        end else if (ce) begin
            b3_acc_q <= fr_end ? 8'h00 : b3_sum;
            if (fr_end) b3_q <= b3_sum; // R09
            if (rx_rei.valid) begin
                rei_q <= (rx_rei.count > REI_MAX) ? REI_MAX :
                         rx_rei.count; // R16
            end else if (slot == SL_POH && row_q == ROW_G1) begin
                rei_q <= 4'h0;
            end
            cell_ready_q <= pay_nx && !ppp; // R07
            pkt_ready_q <= pay_nx && ppp; // R08
            out_q.valid <= 1'b1;
            out_q.sof <= row_q == 4'h0 && col_q == 9'h000;
            out_q.row <= row_q;
            out_q.col <= col_q;
            out_q.data <= byte_d; // R22
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cell_ready = cell_ready_q;
    assign pkt_ready = pkt_ready_q;
    assign tx_out = out_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ndf_nibble: assert property ( // R01
        ce && slot == SL_H1 && ndf_plain_q && ndf_frame && !ais
        |=> tx_out.data[7:4] == NDF_ON)
        else $error("flag nibble not 1001 in flagged frame");
    a_ndf_capture: assert property ( // R02
        ndf_go && !take_frc |=> ndf_lo_q == $past(arb_lo_q) &&
        ndf_h1_q[1:0] == $past(arb_hi_q[1:0]))
        else $error("arbitrary pointer not captured");
    a_ndf_normal: assert property ( // R03
        ce && slot == SL_H1 && !ndf_frame && !ais
        |=> tx_out.data[7:4] == NDF_OFF)
        else $error("flag nibble not 0110 in normal frame");
    a_ndf_load: assert property ( // R03
        fr_end && ndf_frame
        |=> ptr_q == $past({ndf_h1_q[1:0], ndf_lo_q}))
        else $error("new pointer not adopted");
    a_trig_clear: assert property ( // R04
        take_sndf && !set_sndf |=> !pend_sndf_q)
        else $error("single flag trigger did not clear");
    a_trig_once: assert property ( // R26
        !pend_sndf_q && !set_sndf |=> !pend_sndf_q ##0
        (ev_q != EV_NDF || !ndf_plain_q || $past(cndf_q) ||
         $past(ev_q) == EV_NDF || !$past(fr_end)))
        else $error("flag event without a written trigger");
    a_b3_insert: assert property ( // R23
        ce && slot == SL_POH && row_q == ROW_B3 && !ais
        |=> tx_out.data == $past(b3_q ^ mask_q))
        else $error("B3 byte not parity xor mask");
    a_rdi_auto: assert property ( // R13
        ce && slot == SL_POH && row_q == ROW_G1 && !ais && |rx_def
        |=> tx_out.data[3])
        else $error("remote defect missing during receive defect");
    a_rei_latch: assert property ( // R16
        ce && rx_rei.valid && rx_rei.count != 4'h0 |=> rei_q != 4'h0)
        else $error("remote error count lost");
    a_ais_fill: assert property ( // R18
        ce && ais && slot != SL_TOH |=> tx_out.data == AIS_BYTE)
        else $error("alarm byte not all ones");
    a_ptr_inc: assert property ( // R24
        fr_end && ev_q == EV_INC && ptr_q != PTR_MAX
        |=> ptr_q == $past(ptr_q) + 10'h001)
        else $error("pointer not incremented");
    a_ptr_dec: assert property ( // R25
        fr_end && ev_q == EV_DEC && ptr_q != 10'h000
        |=> ptr_q == $past(ptr_q) - 10'h001)
        else $error("pointer not decremented");
    a_pay_slot: assert property ( // R07
        ce && (cell_ready_q || pkt_ready_q) |-> slot == SL_PAY)
        else $error("ready outside a payload slot");
    a_frame_geom: assert property ( // R10
        tx_out.valid |-> tx_out.col < COLS && tx_out.row < ROWS)
        else $error("position outside the frame");

    c_ndf_frame: cover property (fr_end && ndf_go);
    c_pos_stuff: cover property (ce && slot == SL_STUFF);
    c_neg_stuff: cover property (fr_end && ev_q == EV_DEC);
    c_force: cover property (take_frc);
endmodule : txpo_top
`default_nettype wire

// >>> txpo_cell_src.sv
// Upstream cell source that offers a counting byte on every cycle.
`default_nettype none
module txpo_cell_src
    import txpo_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Cell byte handshake.
    input wire logic cell_ready,
    output var txpo_pay_t cell_in
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_in <= '0;
        end else begin
            cell_in.valid <= 1'b1;
            if (cell_ready && cell_in.valid) begin
                cell_in.data <= cell_in.data + 8'h01;
            end
        end
    end
endmodule : txpo_cell_src
`default_nettype wire

// >>> test_tx_path_overhead_pointer_gen.sv
// Bench for the pointer registers, flag events and stuff events.
`default_nettype none
module test_tx_path_overhead_pointer_gen
    import txpo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    txpo_defect_t rx_def = '0;
    txpo_rei_t rx_rei = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rdv;
    logic pready;
    logic pslverr;
    logic er;
    logic cell_ready;
    logic pkt_ready;
    logic [7:0] h1;
    logic [7:0] h2;
    txpo_pay_t cell_in;
    txpo_byte_t tx_out;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    txpo_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cell_in(cell_in), .cell_ready(cell_ready), .pkt_in('0),
        .pkt_ready(pkt_ready), .rx_def(rx_def), .rx_rei(rx_rei),
        .tx_out(tx_out));
    txpo_cell_src src (.pclk(pclk), .presetn(presetn),
        .cell_ready(cell_ready), .cell_in(cell_in));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic end_sim;
        $display("counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cw(input string nm, input logic [15:0] e);
        chk(nm, {16'h0, e}, {16'h0, h1, h2});
    endtask : cw
    task automatic apb(input logic w, input logic [13:0] ix,
            input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdv = prdata;
        er = pslverr;
        if (n >= 16) fail_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rc(input string nm, input logic [13:0] ix,
            input logic [31:0] e);
        apb(1'b0, ix, 8'h00);
        chk(nm, e, rdv);
    endtask : rc
    task automatic at(input logic [3:0] r, input logic [8:0] c,
            output logic [7:0] d);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!(tx_out.valid === 1'b1 && tx_out.row === r &&
            tx_out.col === c) && n < 3000);
        d = tx_out.data;
        if (n >= 3000) fail_count++;
    endtask : at
    // Captures the pointer bytes of the frame that starts next.
    task automatic hw;
        at(4'h0, 9'h000, h1);
        at(H_ROW, H1_COL, h1);
        at(H_ROW, H2_COL, h2);
    endtask : hw
    task automatic stuff(input logic [7:0] cmd, input logic [9:0] w,
            input logic [9:0] nx);
        apb(1'b1, IX_CTRL, cmd);
        hw;
        cw("adj word", {NDF_OFF, SS_BITS, w});
        rc("adj ctrl", IX_CTRL, 32'h0);
        hw;
        cw("adj ptr", {NDF_OFF, SS_BITS, nx});
    endtask : stuff
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 25000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rc("ctrl rst", IX_CTRL, 32'h0);
        rc("hi rst", IX_ARB_HI, 32'h0);
        rc("lo rst", IX_ARB_LO, 32'h0);
        apb(1'b0, 14'h0001, 8'h00);
        chk("unmapped err", 32'h1, {31'h0, er});
        $display("test reset done");
        apb(1'b1, IX_ARB_HI, 8'hf6);
        apb(1'b1, IX_ARB_LO, 8'h34);
        rc("hi rw", IX_ARB_HI, 32'hf6);
        apb(1'b1, IX_CTRL, 8'h01);
        rc("ctrl pend", IX_CTRL, 32'h1);
        hw;
        cw("flag word", {NDF_ON, SS_BITS, 10'h234});
        rc("ctrl clr", IX_CTRL, 32'h0);
        hw;
        cw("new word", {NDF_OFF, SS_BITS, 10'h234});
        rc("ptr lo", IX_PTR_LO, 32'h34);
        $display("test single flag done");
        stuff(8'h04, 10'h234 ^ I_MASK, 10'h235);
        stuff(8'h08, 10'h235 ^ D_MASK, 10'h234);
        $display("test stuff done");
        rx_def.lcd <= 1'b1;
        rx_rei <= '{1'b1, 4'h3};
        @(posedge pclk);
        rx_rei <= '0;
        at(ROW_G1, TOH_COLS, h1);
        chk("g1 byte", 32'h38, {24'h0, h1});
        rx_def <= '0;
        at(4'h0, 9'h000, h1);
        chk("sof", 32'h1, {31'h0, tx_out.sof});
        at(4'h0, 9'h00a, h1);
        at(4'h0, 9'h00b, h2);
        h1 = h1 + 8'h01;
        chk("cell order", {24'h0, h1}, {24'h0, h2});
        chk("pkt ready", 32'h0, {31'h0, pkt_ready});
        apb(1'b1, IX_CFG, 8'h01);
        at(H_ROW, H1_COL, h1);
        chk("ais h1", {24'h0, AIS_BYTE}, {24'h0, h1});
        chk("ais ready", 32'h0, {31'h0, cell_ready});
        ce <= 1'b0;
        @(posedge pclk);
        h2 = tx_out.col[7:0];
        repeat (3) @(posedge pclk);
        chk("freeze col", {24'h0, h2}, {24'h0, tx_out.col[7:0]});
        ce <= 1'b1;
        $display("test alarms done");
        end_sim();
    end
endmodule : test_tx_path_overhead_pointer_gen
`default_nettype wire
